/* qpcc_fabric_model.sv */
// Fabric-side model: reference selection, numerator port, PLL resets and tick sources
`timescale 1ns/10ps
`default_nettype none

module qpcc_fabric_model (
  input  wire logic             mclk,                       // System clock
  input  wire logic             rst,                        // Sync reset
  input  wire logic [1:0][2:0]  want_sel,                   // Requested ref code
  input  wire logic [1:0][25:0] want_num,                   // Requested numerator
  input  wire logic             detune,                     // Feedback off frequency
  input  wire logic [1:0]       lc_hold,                    // LC reset request
  output logic      [1:0][2:0]  ring_pll_ref_select,        // Ref code to block
  output logic      [1:0][25:0] ring_pll_frac_numerator_in, // Numerator to block
  output logic      [3:0]       pll_reset,                  // Ring 0/1, LC 0/1
  output logic      [3:0]       ref_tick,                   // Reference events
  output logic      [3:0]       fb_tick,                    // Feedback events
  output logic      [1:0]       lc_vco_tick                 // VCO events
);
  logic [3:0]      cnt_q;
  logic [1:0][2:0] rcnt_q;

  always_ff @(posedge mclk) begin
    if (rst) begin
      cnt_q               <= 4'h0;
      rcnt_q              <= '0;
      ring_pll_ref_select <= {2{3'h1}};
    end else begin
      cnt_q <= cnt_q + 4'h1;
      for (int h = 0; h < 2; h++) begin
        ring_pll_ref_select[h] <= want_sel[h];
        // A new reference is never trusted without a fresh PLL reset
        if (want_sel[h] != ring_pll_ref_select[h]) rcnt_q[h] <= 3'h4;
        else if (rcnt_q[h] != 3'h0) rcnt_q[h] <= rcnt_q[h] - 3'h1;
      end
    end
  end

  // Port numerator kept within 24 bits, as the fraction allows
  assign ring_pll_frac_numerator_in = {{2'h0, want_num[1][23:0]},
                                       {2'h0, want_num[0][23:0]}};
  assign pll_reset   = {lc_hold, rcnt_q[1] != 3'h0, rcnt_q[0] != 3'h0};
  assign ref_tick    = {4{cnt_q[0]}};
  assign fb_tick     = detune ? {4{cnt_q[1:0] == 2'h3}} : {4{cnt_q[0]}};
  assign lc_vco_tick = {2{cnt_q[0]}};
endmodule // qpcc_fabric_model

`default_nettype wire

/* qpcc_pkg.sv */
// Shared constants for the quad PLL configuration and control block
package qpcc_pkg;
  localparam int NREG = 16;
  localparam int AW   = 12;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [11:0] OFS_LANE0_DIV  = 12'hCA0;
  localparam logic [11:0] OFS_R0_LOCK    = 12'hD0C;
  localparam logic [11:0] OFS_R0_WIDTH   = 12'hD0D;
  localparam logic [11:0] OFS_R0_REFDIV  = 12'hD0F;
  localparam logic [11:0] OFS_LANE1_DIV  = 12'hDA0;
  localparam logic [11:0] OFS_FRAC_SRC   = 12'hE10;
  localparam logic [11:0] OFS_FBDIV      = 12'hE12;
  localparam logic [11:0] OFS_LANE2_DIV  = 12'hEA0;
  localparam logic [11:0] OFS_R0_NUM     = 12'hF03;
  localparam logic [11:0] OFS_R1_LOCK    = 12'hF0C;
  localparam logic [11:0] OFS_R1_WIDTH   = 12'hF0D;
  localparam logic [11:0] OFS_R1_REFDIV  = 12'hF0F;
  localparam logic [11:0] OFS_R1_NUM     = 12'hF11;
  localparam logic [11:0] OFS_LANE3_DIV  = 12'hFA0;
  localparam logic [11:0] OFS_PLL_MODE   = 12'hC01;
  localparam logic [11:0] OFS_LANE_SRC   = 12'hC02;
  localparam logic [11:0] OFS_STATUS     = 12'hC00;
  localparam logic [11:0] REG_OFS [NREG] = '{
    OFS_LANE0_DIV, OFS_R0_LOCK, OFS_R0_WIDTH, OFS_R0_REFDIV,
    OFS_LANE1_DIV, OFS_FRAC_SRC, OFS_FBDIV, OFS_LANE2_DIV,
    OFS_R0_NUM, OFS_R1_LOCK, OFS_R1_WIDTH, OFS_R1_REFDIV,
    OFS_R1_NUM, OFS_LANE3_DIV, OFS_PLL_MODE, OFS_LANE_SRC};

  // Storage indices: shared, per clock half or per lane
  localparam int IX_FSEL   = 5;
  localparam int IX_FBDIV  = 6;
  localparam int IX_MODE   = 14;
  localparam int IX_LSRC   = 15;
  localparam int IX_LOCK   [2] = '{1, 9};
  localparam int IX_WIDTH  [2] = '{2, 10};
  localparam int IX_REFDIV [2] = '{3, 11};
  localparam int IX_NUM    [2] = '{8, 12};
  localparam int IX_LANE   [4] = '{0, 4, 7, 13};

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int FSEL_BIT [2] = '{11, 21};
  localparam int FBN_LSB  [2] = '{8, 24};
  localparam int FBN_W        = 8;
  localparam int NUM_W        = 26;
  localparam int RX_LSB       = 26;
  localparam int TX_LSB       = 23;
  localparam int DIV_W        = 3;
  localparam int REFDIV_W     = 5;
  localparam int LOCKEN_BIT   = 11;
  localparam int WSEL_LSB     = 9;
  localparam int MODE_STRIDE  = 8;
  localparam int MODE_HALF    = 0;
  localparam int MODE_LCLOCK  = 1;
  localparam int MODE_FAST    = 2;
  localparam int MODE_LCFRAC  = 3;
  localparam int MODE_RFRAC   = 4;
  localparam int ST_RLOCK     = 0;
  localparam int ST_LCLOCK    = 2;
  localparam int ST_OVF       = 4;
  localparam int ST_NOK       = 6;

  // ----------------------------------------------------------------
  // Reset values, limits and timing counts
  // ----------------------------------------------------------------
  localparam logic [31:0] FBDIV_RST = 32'h1440_1440;
  localparam logic [31:0] LOCK_RST  = 32'h0000_0800;
  localparam logic [31:0] MODE_RST  = 32'h0000_0202;
  localparam logic [31:0] REG_RST [NREG] = '{
    32'h0, LOCK_RST, 32'h0, 32'h0, 32'h0, 32'h0, FBDIV_RST, 32'h0,
    32'h0, LOCK_RST, 32'h0, 32'h0, 32'h0, 32'h0, MODE_RST, 32'h0};
  localparam logic [7:0] RN_LO   = 8'h05;
  localparam logic [7:0] RN_HI   = 8'h19;
  localparam logic [7:0] RN_A    = 8'h20;
  localparam logic [7:0] RN_B    = 8'h21;
  localparam logic [7:0] RN_TOP  = 8'h50;
  localparam logic [7:0] RNF_LO  = 8'h08;
  localparam int LOCK_WINDOW_DEF = 256;
  localparam int LOCK_TOL_DEF    = 2;
endpackage

/* qpcc_top.sv */
// Quad PLL configuration registers, divider decoding and lock detection
//
// Summary of operation
// - Ring reference select codes 1-7 route one source, code 0 none
// - Ring lock high only within frequency tolerance
// - 26-bit port supplies numerator in port mode
// - Source bits 21/11 pick attribute or port
// - Ring N fields; integer N 5-25,32,33,80
// - Attribute numerators are 26-bit register fields
// - Lane divider codes 000-100 give 1..16
// - Reference divider M decodes 2,3,4,1
// - Bit 11 enables ring lock detector
// - Width code selects 24, 20, 16 bits
// - Fraction is numerator over two^width
// - LC output rate full or half VCO
// - LC fraction bypassed above 30.5 Gb/s
// - LC half 0 lanes 0/1, half 1 2/3
// - LC lock compares reference and feedback
// - Ring half 0 lanes 0/1, half 1 2/3
//
// The strobed register port is this design's own decision.
`timescale 1ns/10ps
`default_nettype none

module qpcc_top #(
  parameter int LOCK_WINDOW = qpcc_pkg::LOCK_WINDOW_DEF, // Lock compare window
  parameter int LOCK_TOL    = qpcc_pkg::LOCK_TOL_DEF     // Allowed count gap
) (
  input  wire logic             mclk,                // System clock
  input  wire logic             rst,                 // Sync reset
  input  wire logic [11:0]      reg_addr,            // Register offset
  input  wire logic [31:0]      reg_wdata,           // Write data
  input  wire logic             reg_wr,              // Write strobe
  input  wire logic             reg_rd,              // Read strobe
  output logic      [31:0]      reg_rdata,           // Read data
  input  wire logic [1:0][2:0]  ring_pll_ref_select, // Per half ref code
  input  wire logic [1:0][25:0] ring_pll_frac_numerator_in, // Port value
  input  wire logic [3:0]       pll_reset,           // Ring 0/1, LC 0/1
  input  wire logic [3:0]       ref_tick,            // Divided ref event
  input  wire logic [3:0]       fb_tick,             // Divided feedback
  input  wire logic [1:0]       lc_vco_tick,         // LC VCO event
  output logic      [1:0][6:0]  ring_ref_route,      // One-hot source
  output logic      [1:0]       ring_pll_locked,     // Ring lock
  output logic      [1:0]       lc_pll_locked,       // LC lock
  output logic      [1:0][25:0] frac_numerator_eff,  // Chosen numerator
  output logic      [1:0][23:0] frac_part,           // Fraction, 24 bits
  output logic      [1:0]       frac_numerator_ovf,  // Above 2^24-1
  output logic      [1:0][4:0]  frac_den_width,      // 24/20/16, 0 bad
  output logic      [1:0][2:0]  ring_ref_div,        // M, 0 bad
  output logic      [1:0][7:0]  ring_feedback_n,     // N field
  output logic      [1:0]       ring_n_valid,        // N in range
  output logic      [3:0][4:0]  rx_div_ratio,        // 1..16, 0 bad
  output logic      [3:0][4:0]  tx_div_ratio,        // 1..16, 0 bad
  output logic      [3:0][1:0]  lane_clock_src,      // {half, lc}
  output logic      [1:0]       lc_out_tick,         // LC output event
  output logic      [1:0]       lc_frac_active       // LC fraction used
);

  localparam int CW = $clog2(LOCK_WINDOW) + 1;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [qpcc_pkg::NREG-1:0][31:0] regs;
    logic [31:0]        rdata;
    logic [1:0][6:0]    route;
    logic [1:0][25:0]   num_eff;
    logic [1:0][23:0]   frac;
    logic [1:0]         num_ovf;
    logic [1:0][4:0]    den_w;
    logic [1:0][2:0]    m_div;
    logic [1:0][7:0]    ring_n;
    logic [1:0]         n_ok;
    logic [3:0][4:0]    rx_ratio;
    logic [3:0][4:0]    tx_ratio;
    logic [3:0][1:0]    lane_src;
    logic [1:0]         lc_phase;
    logic [1:0]         lc_tick;
    logic [1:0]         lc_frac;
    logic [3:0][CW-1:0] win;
    logic [3:0][CW-1:0] ref_cnt;
    logic [3:0][CW-1:0] fb_cnt;
    logic [3:0]         locked;
  } qpcc_state_t;

  qpcc_state_t q;
  qpcc_state_t d;

  // ----------------------------------------------------------------
  // Decoders
  // ----------------------------------------------------------------
  function automatic logic [4:0] lookup(input logic [11:0] a);
    logic [4:0] r;
    r = 5'h00;
    for (int i = 0; i < qpcc_pkg::NREG; i++) begin
      if (a == qpcc_pkg::REG_OFS[i]) begin
        r = {1'b1, 4'(i)};
      end
    end
    return r;
  endfunction

  function automatic logic [4:0] serial_div(input logic [2:0] c);
    return (c <= 3'h4) ? 5'(5'h01 << c) : 5'h00;
  endfunction

  function automatic logic [6:0] ref_route(input logic [2:0] s);
    return (s == 3'h0) ? 7'h00 : 7'(7'h01 << (s - 3'h1));
  endfunction

  function automatic logic [2:0] m_decode(input logic [4:0] c);
    case (c)
      5'h00:   return 3'h2;
      5'h01:   return 3'h3;
      5'h02:   return 3'h4;
      5'h04:   return 3'h1;
      default: return 3'h0;
    endcase
  endfunction

  function automatic logic [4:0] width_decode(input logic [1:0] c);
    case (c)
      2'h0:    return 5'h18;
      2'h1:    return 5'h14;
      2'h2:    return 5'h10;
      default: return 5'h00;
    endcase
  endfunction

  function automatic logic n_valid(input logic [7:0] n, input logic fr);
    if (fr) begin
      return (n >= qpcc_pkg::RNF_LO) && (n <= qpcc_pkg::RN_TOP);
    end
    return ((n >= qpcc_pkg::RN_LO) && (n <= qpcc_pkg::RN_HI)) ||
           (n == qpcc_pkg::RN_A) || (n == qpcc_pkg::RN_B) ||
           (n == qpcc_pkg::RN_TOP);
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [4:0]    hit;
    logic [7:0]    mode;
    logic [25:0]   num;
    logic [1:0]    wsel;
    logic [3:0]    lock_en;
    logic [CW-1:0] rn;
    logic [CW-1:0] fn;
    logic [CW-1:0] gap;
    logic [31:0]   status;
    hit     = lookup(reg_addr);
    mode    = 8'h00;
    num     = 26'h0;
    wsel    = 2'h0;
    lock_en = 4'h0;
    rn      = '0;
    fn      = '0;
    gap     = '0;
    status  = 32'h0;
    d       = q;
    d.rdata = 32'h0;

    // Register port: reads see the state before a same-cycle write
    status[qpcc_pkg::ST_RLOCK +: 2]  = q.locked[1:0];
    status[qpcc_pkg::ST_LCLOCK +: 2] = q.locked[3:2];
    status[qpcc_pkg::ST_OVF +: 2]    = q.num_ovf;
    status[qpcc_pkg::ST_NOK +: 2]    = q.n_ok;
    if (reg_rd) begin
      if (hit[4]) begin
        d.rdata = q.regs[hit[3:0]];
      end else if (reg_addr == qpcc_pkg::OFS_STATUS) begin
        d.rdata = status;
      end
    end
    if (reg_wr && hit[4]) begin
      d.regs[hit[3:0]] = reg_wdata;
    end

    for (int h = 0; h < 2; h++) begin
      mode = q.regs[qpcc_pkg::IX_MODE][h*qpcc_pkg::MODE_STRIDE +: 8];
      d.route[h] = ref_route(ring_pll_ref_select[h]);
      if (q.regs[qpcc_pkg::IX_FSEL][qpcc_pkg::FSEL_BIT[h]]) begin
        num = ring_pll_frac_numerator_in[h];
      end else begin
        num = q.regs[qpcc_pkg::IX_NUM[h]][qpcc_pkg::NUM_W-1:0];
      end
      d.num_eff[h] = num;
      d.num_ovf[h] = |num[25:24];
      wsel = q.regs[qpcc_pkg::IX_WIDTH[h]][qpcc_pkg::WSEL_LSB +: 2];
      d.den_w[h] = width_decode(wsel);
      // Fraction scaled to 2^24 so every width reads on one scale
      case (wsel)
        2'h0:    d.frac[h] = num[23:0];
        2'h1:    d.frac[h] = {num[19:0], 4'h0};
        2'h2:    d.frac[h] = {num[15:0], 8'h00};
        default: d.frac[h] = 24'h0;
      endcase
      d.m_div[h] = m_decode(q.regs[qpcc_pkg::IX_REFDIV[h]][qpcc_pkg::REFDIV_W-1:0]);
      d.ring_n[h] = q.regs[qpcc_pkg::IX_FBDIV][qpcc_pkg::FBN_LSB[h] +: 8];
      d.n_ok[h] = n_valid(d.ring_n[h], mode[qpcc_pkg::MODE_RFRAC]);
      // Fraction only takes effect at or below the top fractional rate
      d.lc_frac[h] = mode[qpcc_pkg::MODE_LCFRAC] & ~mode[qpcc_pkg::MODE_FAST];
      lock_en[h] = q.regs[qpcc_pkg::IX_LOCK[h]][qpcc_pkg::LOCKEN_BIT];
      lock_en[h+2] = mode[qpcc_pkg::MODE_LCLOCK];
      if (pll_reset[h+2]) begin
        d.lc_phase[h] = 1'b0;
        d.lc_tick[h]  = 1'b0;
      end else begin
        d.lc_tick[h] = lc_vco_tick[h] & (~mode[qpcc_pkg::MODE_HALF] | q.lc_phase[h]);
        d.lc_phase[h] = q.lc_phase[h] ^ lc_vco_tick[h];
      end
    end

    for (int l = 0; l < 4; l++) begin
      d.rx_ratio[l] = serial_div(q.regs[qpcc_pkg::IX_LANE[l]][qpcc_pkg::RX_LSB +: 3]);
      d.tx_ratio[l] = serial_div(q.regs[qpcc_pkg::IX_LANE[l]][qpcc_pkg::TX_LSB +: 3]);
      // Half is fixed by lane number; software only picks ring or LC
      d.lane_src[l] = {l >= 2, q.regs[qpcc_pkg::IX_LSRC][l]};
    end

    // Frequency comparison of reference and feedback over a window
    for (int p = 0; p < 4; p++) begin
      rn  = q.ref_cnt[p] + CW'(ref_tick[p]);
      fn  = q.fb_cnt[p] + CW'(fb_tick[p]);
      gap = (rn > fn) ? rn - fn : fn - rn;
      if (pll_reset[p] || !lock_en[p]) begin
        d.win[p]     = '0;
        d.ref_cnt[p] = '0;
        d.fb_cnt[p]  = '0;
        d.locked[p]  = 1'b0;
      end else if (q.win[p] == CW'(LOCK_WINDOW - 1)) begin
        d.win[p]     = '0;
        d.ref_cnt[p] = '0;
        d.fb_cnt[p]  = '0;
        d.locked[p]  = (gap <= CW'(LOCK_TOL)) && (rn != '0);
      end else begin
        d.win[p]     = q.win[p] + CW'(1);
        d.ref_cnt[p] = rn;
        d.fb_cnt[p]  = fn;
      end
    end

    if (rst) begin
      d = '0;
      for (int i = 0; i < qpcc_pkg::NREG; i++) begin
        d.regs[i] = qpcc_pkg::REG_RST[i];
      end
    end
  end

  always_ff @(posedge mclk) begin
    q <= d;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign reg_rdata          = q.rdata;
  assign ring_ref_route     = q.route;
  assign ring_pll_locked    = q.locked[1:0];
  assign lc_pll_locked      = q.locked[3:2];
  assign frac_numerator_eff = q.num_eff;
  assign frac_part          = q.frac;
  assign frac_numerator_ovf = q.num_ovf;
  assign frac_den_width     = q.den_w;
  assign ring_ref_div       = q.m_div;
  assign ring_feedback_n    = q.ring_n;
  assign ring_n_valid       = q.n_ok;
  assign rx_div_ratio       = q.rx_ratio;
  assign tx_div_ratio       = q.tx_ratio;
  assign lane_clock_src     = q.lane_src;
  assign lc_out_tick        = q.lc_tick;
  assign lc_frac_active     = q.lc_frac;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_route_global;
    @(posedge mclk) disable iff (rst)
    ring_pll_ref_select[0] == 3'h7 |=> q.route[0] == 7'h40;
  endproperty
  a_route_global: assert property (p_route_global)
    else $error("global reference not routed");
  property p_num_port;
    @(posedge mclk) disable iff (rst)
    q.regs[5][21] |=> q.num_eff[1] == $past(ring_pll_frac_numerator_in[1]);
  endproperty
  a_num_port: assert property (p_num_port)
    else $error("port numerator not selected");
  property p_num_attr;
    @(posedge mclk) disable iff (rst)
    !q.regs[5][11] |=> q.num_eff[0] == $past(q.regs[8][25:0]);
  endproperty
  a_num_attr: assert property (p_num_attr)
    else $error("attribute numerator not selected");
  property p_n_check;
    @(posedge mclk) disable iff (rst)
    (q.regs[6][15:8] == 8'h1A) && !q.regs[14][4] |=> !q.n_ok[0];
  endproperty
  a_n_check: assert property (p_n_check)
    else $error("invalid integer N accepted");
  property p_serial16;
    @(posedge mclk) disable iff (rst)
    q.regs[0][28:26] == 3'h4 |=> q.rx_ratio[0] == 5'h10;
  endproperty
  a_serial16: assert property (p_serial16)
    else $error("divide by 16 not decoded");
  property p_m_one;
    @(posedge mclk) disable iff (rst)
    q.regs[3][4:0] == 5'h04 |=> q.m_div[0] == 3'h1;
  endproperty
  a_m_one: assert property (p_m_one)
    else $error("M code 00100 not decoded as 1");
  property p_lock_off;
    @(posedge mclk) disable iff (rst)
    !q.regs[1][11] |=> !q.locked[0];
  endproperty
  a_lock_off: assert property (p_lock_off)
    else $error("lock reported with detector off");
  property p_width16;
    @(posedge mclk) disable iff (rst)
    q.den_w[1] == 5'h10 |-> q.frac[1] == {q.num_eff[1][15:0], 8'h00};
  endproperty
  a_width16: assert property (p_width16)
    else $error("16-bit fraction misaligned");
  property p_half_rate;
    @(posedge mclk) disable iff (rst)
    q.lc_tick[0] |-> $past(lc_vco_tick[0]) &&
      (!$past(q.regs[14][0]) || $past(q.lc_phase[0]));
  endproperty
  a_half_rate: assert property (p_half_rate)
    else $error("LC output event at wrong rate");
  property p_bypass;
    @(posedge mclk) disable iff (rst)
    q.regs[14][10] |=> !q.lc_frac[1];
  endproperty
  a_bypass: assert property (p_bypass)
    else $error("fraction active above top rate");
  // Decodes are still cleared in the cycle right after reset
  property p_lane_half;
    @(posedge mclk) disable iff (rst)
    !$past(rst) |-> !q.lane_src[0][1] && !q.lane_src[1][1] &&
    q.lane_src[2][1] && q.lane_src[3][1];
  endproperty
  a_lane_half: assert property (p_lane_half)
    else $error("lane fed from wrong clock half");
  property p_lock_rise;
    @(posedge mclk) disable iff (rst)
    $rose(q.locked[2]) |-> $past(q.win[2]) == CW'(LOCK_WINDOW - 1);
  endproperty
  a_lock_rise: assert property (p_lock_rise)
    else $error("lock rose outside window end");
  property p_reset_lock;
    @(posedge mclk) disable iff (rst)
    pll_reset[0] |=> !q.locked[0] ##1 !q.locked[0];
  endproperty
  a_reset_lock: assert property (p_reset_lock)
    else $error("lock held through PLL reset");

endmodule // qpcc_top

`default_nettype wire

/* qpcc_top_test.sv */
// Self-checking testbench for the quad PLL configuration block
`timescale 1ns/10ps
`default_nettype none

module qpcc_top_test;
  logic mclk, rst, reg_wr, reg_rd, detune;
  logic [11:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, d;
  logic [1:0][2:0] want_sel, sel;
  logic [1:0][25:0] want_num, num_in, fne;
  logic [3:0] prst, rtk, ftk;
  logic [1:0] lc_hold, vtk, rlk, llk, ovf, nok, otk, lfa;
  logic [1:0][6:0] route;
  logic [1:0][23:0] fpart;
  logic [1:0][4:0] fw;
  logic [1:0][2:0] mdiv;
  logic [1:0][7:0] fbn;
  logic [3:0][4:0] rxr, txr;
  logic [3:0][1:0] lsrc;
  int fails, checks;
  int no [2];
  int nv [2];
  localparam int WID [4] = '{24, 20, 16, 0};
  localparam int MC [5] = '{0, 1, 2, 4, 3};
  localparam int MV [5] = '{2, 3, 4, 1, 0};
  localparam int NV [12] = '{4, 5, 25, 26, 32, 33, 34, 80, 81, 7, 8, 81};
  localparam int NOK [12] = '{0, 1, 1, 0, 1, 1, 0, 1, 0, 0, 1, 0};

  qpcc_fabric_model fab_u (.mclk(mclk), .rst(rst), .want_sel(want_sel),
    .want_num(want_num), .detune(detune), .lc_hold(lc_hold),
    .ring_pll_ref_select(sel), .ring_pll_frac_numerator_in(num_in),
    .pll_reset(prst), .ref_tick(rtk), .fb_tick(ftk), .lc_vco_tick(vtk));

  // Short lock window keeps lock scenarios quick
  qpcc_top #(.LOCK_WINDOW(8), .LOCK_TOL(1)) dut_u (.mclk(mclk), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .ring_pll_ref_select(sel), .ring_pll_frac_numerator_in(num_in),
    .pll_reset(prst), .ref_tick(rtk), .fb_tick(ftk), .lc_vco_tick(vtk),
    .ring_ref_route(route), .ring_pll_locked(rlk), .lc_pll_locked(llk),
    .frac_numerator_eff(fne), .frac_part(fpart), .frac_numerator_ovf(ovf),
    .frac_den_width(fw), .ring_ref_div(mdiv), .ring_feedback_n(fbn),
    .ring_n_valid(nok), .rx_div_ratio(rxr), .tx_div_ratio(txr),
    .lane_clock_src(lsrc), .lc_out_tick(otk), .lc_frac_active(lfa));

  always #5 mclk = ~mclk;

  // ------------------------------------------------------------------
  // Bus tasks and checks
  // ------------------------------------------------------------------
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] v);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    v = reg_rdata;
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  function automatic logic [4:0] ratio(input int c);
    return c < 5 ? 5'(1 << c) : 5'h00;
  endfunction

  task automatic final_report;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    #300us;
    fails++;
    final_report;
  end

  // ------------------------------------------------------------------
  // Test sequence
  // ------------------------------------------------------------------
  initial begin
    mclk = 1'b0; rst = 1'b1; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 12'h000;
    reg_wdata = 32'h0; want_sel = {3'h1, 3'h1}; want_num = '0; detune = 1'b0;
    lc_hold = 2'h0;
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    for (int i = 0; i < qpcc_pkg::NREG; i++) begin
      rd(qpcc_pkg::REG_OFS[i], d);
      cmp(d, qpcc_pkg::REG_RST[i], "reset value");
    end
    wr(12'h123, 32'hFFFF_FFFF);
    rd(12'h123, d);
    cmp(d, 32'h0, "unmapped read");
    for (int c = 0; c < 8; c++) begin
      want_sel <= {3'(c), 3'(7 - c)};
      step(3);
      cmp(route[1], c == 0 ? 0 : 1 << (c - 1), "route half1");
      cmp(route[0], c == 7 ? 0 : 1 << (6 - c), "route half0");
    end
    for (int l = 0; l < 4; l++) begin
      for (int c = 0; c < 8; c++) begin
        wr(qpcc_pkg::REG_OFS[qpcc_pkg::IX_LANE[l]], (32'(c) << 26) | (32'(7 - c) << 23));
        step(2);
        cmp(rxr[l], ratio(c), "rx divider");
        cmp(txr[l], ratio(7 - c), "tx divider");
      end
    end
    for (int h = 0; h < 2; h++) begin
      for (int i = 0; i < 5; i++) begin
        wr(qpcc_pkg::REG_OFS[qpcc_pkg::IX_REFDIV[h]], 32'(MC[i]));
        step(2);
        cmp(mdiv[h], MV[i], "ref divider");
      end
      for (int c = 0; c < 4; c++) begin
        wr(qpcc_pkg::REG_OFS[qpcc_pkg::IX_WIDTH[h]], 32'(c) << 9);
        wr(qpcc_pkg::REG_OFS[qpcc_pkg::IX_NUM[h]], 32'h00A5_C3E1);
        step(2);
        cmp(fw[h], WID[c], "den width");
        cmp(fne[h], 26'h0A5C3E1, "attr numerator");
        if (c < 3) cmp(fpart[h], 24'(32'h00A5_C3E1 << (24 - WID[c])), "fraction");
        cmp(ovf[h], 0, "no overflow");
      end
      wr(qpcc_pkg::REG_OFS[qpcc_pkg::IX_NUM[h]], 32'h0300_0001);
      want_num[h] <= 26'h3123456;
      step(2);
      cmp(ovf[h], 1, "overflow");
      wr(qpcc_pkg::OFS_FRAC_SRC, 32'h1 << qpcc_pkg::FSEL_BIT[h]);
      step(2);
      cmp(fne[h], 26'h0123456, "port numerator");
      cmp(fne[1 - h], h == 0 ? 26'h0 : 26'h3000001, "other half attr");
      wr(qpcc_pkg::OFS_FRAC_SRC, 32'h0);
      step(2);
      cmp(fne[h], 26'h3000001, "attr again");
    end
    for (int i = 0; i < 12; i++) begin
      wr(qpcc_pkg::OFS_PLL_MODE, qpcc_pkg::MODE_RST | (i > 8 ? 32'h1010 : 32'h0));
      // Fractional ring PLLs are kept off the lanes' datapath
      wr(qpcc_pkg::OFS_LANE_SRC, i > 8 ? 32'hF : 32'h0);
      wr(qpcc_pkg::OFS_FBDIV, (32'(NV[i]) << 24) | (32'(NV[i]) << 8) | 32'h0040_0040);
      step(2);
      for (int h = 0; h < 2; h++) begin
        cmp(fbn[h], NV[i], "feedback n");
        cmp(nok[h], NOK[i], "n valid");
      end
    end
    for (int v = 0; v < 16; v++) begin
      wr(qpcc_pkg::OFS_LANE_SRC, 32'(v));
      step(2);
      for (int l = 0; l < 4; l++) cmp(lsrc[l], {l >= 2, v[l]}, "lane source");
    end
    for (int m = 0; m < 8; m++) begin
      d = {28'h0, m[2], m[1], 1'b0, m[0]};
      wr(qpcc_pkg::OFS_PLL_MODE, qpcc_pkg::MODE_RST | d | (d << 8));
      step(3);
      no = '{0, 0};
      nv = '{0, 0};
      repeat (40) begin
        step(1);
        for (int h = 0; h < 2; h++) begin
          no[h] += otk[h];
          nv[h] += vtk[h];
        end
      end
      for (int h = 0; h < 2; h++) begin
        cmp(no[h], m[0] ? nv[h] / 2 : nv[h], "lc output rate");
        cmp(lfa[h], m[2] & ~m[1], "lc fraction");
      end
    end
    step(30);
    cmp({llk, rlk}, 4'hF, "all locked");
    rd(qpcc_pkg::OFS_STATUS, d);
    cmp(d[3:0], 4'hF, "status lock");
    detune <= 1'b1;
    step(30);
    cmp({llk, rlk}, 4'h0, "off frequency");
    detune <= 1'b0;
    step(30);
    cmp({llk, rlk}, 4'hF, "relocked");
    wr(qpcc_pkg::OFS_R0_LOCK, 32'h0);
    step(3);
    cmp(rlk, 2'b10, "detector off");
    wr(qpcc_pkg::OFS_R0_LOCK, qpcc_pkg::LOCK_RST);
    want_sel[1] <= 3'h1;
    step(3);
    cmp(rlk, 2'b00, "ring in reset");
    lc_hold <= 2'b01;
    step(3);
    cmp(llk, 2'b10, "lc in reset");
    lc_hold <= 2'b00;
    step(30);
    cmp({llk, rlk}, 4'hF, "after reset");
    final_report;
  end
endmodule // qpcc_top_test

`default_nettype wire
